// ### core/uemr_pkg.sv
package uemr_pkg;
	// ==================================================================
	// Sizes
	localparam int EP_NUM    = 3;
	localparam int BUF_BYTES = 8;
	localparam int MAX_PKT   = 10;
	localparam int STAT_CNT  = 2;

	// ==================================================================
	// Endpoint mode encodings
	localparam logic [3:0] MODE_DISABLE    = 4'h0;
	localparam logic [3:0] MODE_NAK_IO     = 4'h1;
	localparam logic [3:0] MODE_STATUS_OUT = 4'h2;
	localparam logic [3:0] MODE_STALL_IO   = 4'h3;
	localparam logic [3:0] MODE_STATUS_IN  = 4'h6;
	localparam logic [3:0] MODE_ACKOUT_STI = 4'hb;
	localparam logic [3:0] MODE_ACKIN_STO  = 4'hf;
	localparam logic [3:0] MODE_NAK_OUT    = 4'h8;
	localparam logic [3:0] MODE_ACK_OUT    = 4'h9;
	localparam logic [3:0] MODE_NAK_IN     = 4'hc;
	localparam logic [3:0] MODE_ACK_IN     = 4'hd;

	// ==================================================================
	// Tokens and replies
	localparam logic [1:0] TOK_SETUP   = 2'h0;
	localparam logic [1:0] TOK_IN      = 2'h1;
	localparam logic [1:0] TOK_OUT     = 2'h2;
	localparam logic [2:0] REPLY_NONE  = 3'h0;
	localparam logic [2:0] REPLY_ACK   = 3'h1;
	localparam logic [2:0] REPLY_NAK   = 3'h2;
	localparam logic [2:0] REPLY_STALL = 3'h3;
	localparam logic [2:0] REPLY_DATA  = 3'h4;

	typedef enum {ACT_IGNORE, ACT_ACCEPT, ACT_NAK, ACT_STALL, ACT_TX0, ACT_TXCNT, ACT_CHECK, ACT_ACK} uemr_act_e;

	// ==================================================================
	// Register map and fields
	localparam logic [7:0] REG_MODE_BASE  = 8'h00;
	localparam logic [7:0] REG_COUNT_BASE = 8'h04;
	localparam logic [7:0] REG_DATA_BASE  = 8'h10;
	localparam int         MODE_F_ACK     = 4;
	localparam int         MODE_F_OUT     = 5;
	localparam int         MODE_F_IN      = 6;
	localparam int         MODE_F_SETUP   = 7;
	localparam int         CNT_F_STALL    = 5;
	localparam int         CNT_F_DVAL     = 6;
	localparam int         CNT_F_TOG      = 7;
	localparam logic [7:0] MODE_RST       = 8'h00;
	localparam logic [7:0] CNT_RST        = 8'h00;
endpackage

// ### core/uemr_act_dec.sv
`timescale 1ns/10ps
module uemr_act_dec
	import uemr_pkg::*;
(
	input  wire logic [3:0] i_mode,
	input  wire logic [1:0] i_tok,
	input  wire logic       i_ctrl,
	input  wire logic       i_stall,
	output uemr_act_e       o_act
);
	// ==================================================================
	// Base reaction of one endpoint to one token
	always_comb begin
		o_act = ACT_IGNORE;
		if (i_ctrl) begin
			unique case (i_mode)
				MODE_NAK_IO:     o_act = (i_tok == TOK_SETUP) ? ACT_ACCEPT : ACT_NAK;
				MODE_STATUS_OUT: o_act = (i_tok == TOK_SETUP) ? ACT_ACCEPT :
					(i_tok == TOK_IN) ? ACT_STALL : ACT_CHECK;
				MODE_STALL_IO:   o_act = (i_tok == TOK_SETUP) ? ACT_ACCEPT : ACT_STALL;
				MODE_STATUS_IN:  o_act = (i_tok == TOK_SETUP) ? ACT_ACCEPT :
					(i_tok == TOK_IN) ? ACT_TX0 : ACT_STALL;
				MODE_ACKOUT_STI: o_act = (i_tok == TOK_SETUP) ? ACT_ACCEPT :
					(i_tok == TOK_IN) ? ACT_TX0 : ACT_ACK;
				MODE_ACKIN_STO:  o_act = (i_tok == TOK_SETUP) ? ACT_ACCEPT :
					(i_tok == TOK_IN) ? ACT_TXCNT : ACT_CHECK;
				default:         o_act = ACT_IGNORE;
			endcase
		end else begin
			unique case (i_mode)
				MODE_NAK_OUT: o_act = (i_tok == TOK_OUT) ? ACT_NAK : ACT_IGNORE;
				MODE_ACK_OUT: o_act = (i_tok != TOK_OUT) ? ACT_IGNORE : (i_stall ? ACT_STALL : ACT_ACK);
				MODE_NAK_IN:  o_act = (i_tok == TOK_IN) ? ACT_NAK : ACT_IGNORE;
				MODE_ACK_IN:  o_act = (i_tok != TOK_IN) ? ACT_IGNORE : (i_stall ? ACT_STALL : ACT_TXCNT);
				default:      o_act = ACT_IGNORE;
			endcase
		end
	end
endmodule

// ### core/uemr_fifo.sv
`timescale 1ns/10ps
module uemr_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_b,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
			$error("uemr_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      fill_q;
	logic             push;
	logic             pop;

	assign o_in_ready  = (fill_q != (AW+1)'(DEPTH));
	assign o_out_valid = (fill_q != '0);
	assign o_out_data  = mem_q[rd_q];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_q] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_q   <= '0;
			rd_q   <= '0;
			fill_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			fill_q <= fill_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule

// ### core/uemr_responder.sv
// Functional notes
// - Every endpoint holds a four-bit mode that selects its reply to each token.
// - Control mode 0001 acknowledges good SETUP and NAKs both IN and OUT.
// - Status-check OUT is accepted only at zero data bytes with toggle one.
// - A status-check OUT meeting both conditions is answered with ACK.
// - A failed status-check OUT gets STALL if received validly, else no reply.
// - Counted replies send as many buffer bytes as the endpoint byte count holds, at most 8.
// - Mode 0011 good SETUP: ACK, set flags, mode 0001, count, toggle, data stored.
// - An invalid SETUP gets no reply and no flag or mode change.
// - Mode 0011 good OUT gets STALL with no register change or event.
// - Mode 0001 good OUT gets NAK with no register change or event.
// - Mode 1111 good two-count toggle-one OUT: ACK, flags, mode 0010, event.
// - Mode 1111 good OUT of other count: STALL, mode 0011, event.
// - Mode 1111 good two-count OUT with toggle zero: STALL, mode 0011, event.
// - Mode 0010 good status OUT: ACK and flags as 1111 but mode kept.
// - Data mode 1001 becomes 1000 after OUT ACK; 1101 becomes 1100 after IN ACK.
`timescale 1ns/10ps
module uemr_responder
	import uemr_pkg::*;
#(
	parameter int FIFO_DEPTH = 2
) (
	input  wire logic                i_clk,
	input  wire logic                i_rst_b,
	input  wire logic                i_tok_valid,
	input  wire logic [1:0]          i_tok_type,
	input  wire logic [1:0]          i_tok_ep,
	input  wire logic [3:0]          i_tok_count,
	input  wire logic                i_tok_dval,
	input  wire logic                i_tok_toggle,
	input  wire logic                i_host_ack,
	input  wire logic                i_rx_valid,
	input  wire logic                i_rx_setup,
	input  wire logic [1:0]          i_rx_ep,
	input  wire logic [7:0]          i_rx_data,
	output logic                     o_reply_valid,
	output logic [2:0]               o_reply_code,
	output logic [3:0]               o_reply_len,
	output logic                     o_tx_valid,
	input  wire logic                i_tx_ready,
	output logic [7:0]               o_tx_data,
	output logic                     o_tx_last,
	output logic [EP_NUM-1:0]        o_ep_event,
	input  wire logic [7:0]          i_reg_addr,
	input  wire logic [7:0]          i_reg_wdata,
	input  wire logic                i_reg_wr,
	input  wire logic                i_reg_rd,
	output logic [7:0]               o_reg_rdata
);
	// ==================================================================
	// State
	logic [7:0]  mode_q [EP_NUM];
	logic [7:0]  cnt_q  [EP_NUM];
	logic [7:0]  mem_q  [EP_NUM*BUF_BYTES];
	logic [3:0]  rx_idx_q;
	logic        pend_q;
	logic [1:0]  pend_ep_q;
	logic [3:0]  tx_left_q;
	logic [2:0]  tx_idx_q;
	logic [1:0]  tx_ep_q;
	uemr_act_e   act;
	uemr_act_e   rx_act;
	logic [1:0]  ep;
	logic        good;
	logic [3:0]  cur_mode;
	logic [2:0]  reply_d;
	logic        upd;
	logic [3:0]  mode_d;
	logic [3:0]  flag_set;
	logic        cnt_upd;
	logic [3:0]  cnt_d;
	logic        tog_d;
	logic        ev;
	logic [3:0]  tx_len;
	logic        tx_push;
	logic        fifo_ready;
	logic        fifo_valid;
	logic [8:0]  fifo_data;
	logic        rx_store;

	assign ep       = (i_tok_ep < 2'(EP_NUM)) ? i_tok_ep : 2'h0;
	assign cur_mode = mode_q[ep][3:0];
	assign good     = i_tok_dval && (i_tok_count <= 4'(MAX_PKT));

	uemr_act_dec u_tok_dec (
		.i_mode  (cur_mode),
		.i_tok   (i_tok_type),
		.i_ctrl  (ep == 2'h0),
		.i_stall (cnt_q[ep][CNT_F_STALL]),
		.o_act   (act)
	);

	uemr_act_dec u_rx_dec (
		.i_mode  (mode_q[(i_rx_ep < 2'(EP_NUM)) ? i_rx_ep : 2'h0][3:0]),
		.i_tok   (i_rx_setup ? TOK_SETUP : TOK_OUT),
		.i_ctrl  (i_rx_ep == 2'h0),
		.i_stall (cnt_q[(i_rx_ep < 2'(EP_NUM)) ? i_rx_ep : 2'h0][CNT_F_STALL]),
		.o_act   (rx_act)
	);

	assign rx_store = i_rx_valid && (i_rx_ep < 2'(EP_NUM)) && (rx_act == ACT_ACCEPT || rx_act == ACT_ACK) &&
		(rx_idx_q < 4'(BUF_BYTES));

	// ==================================================================
	// Token evaluation
	always_comb begin
		reply_d  = REPLY_NONE;
		upd      = 1'b0;
		mode_d   = cur_mode;
		flag_set = 4'h0;
		cnt_upd  = 1'b0;
		cnt_d    = i_tok_count;
		tog_d    = i_tok_toggle;
		ev       = 1'b0;
		tx_len   = 4'h0;
		unique case (act)
			ACT_IGNORE: begin
			end
			ACT_ACCEPT: if (good) begin
				reply_d  = REPLY_ACK;
				upd      = 1'b1;
				mode_d   = MODE_NAK_IO;
				flag_set = 4'b1001;
				cnt_upd  = 1'b1;
				ev       = 1'b1;
			end
			ACT_NAK: if (i_tok_type == TOK_IN || good) begin
				reply_d = REPLY_NAK;
			end
			ACT_STALL: if (i_tok_type == TOK_IN || good) begin
				reply_d = REPLY_STALL;
				if (cur_mode == MODE_STATUS_OUT || cur_mode == MODE_STATUS_IN) begin
					upd    = 1'b1;
					mode_d = MODE_STALL_IO;
					ev     = 1'b1;
				end
			end
			ACT_CHECK: if (good) begin
				upd = 1'b1;
				ev  = 1'b1;
				if (i_tok_count == 4'(STAT_CNT) && i_tok_toggle) begin
					reply_d  = REPLY_ACK;
					mode_d   = (cur_mode == MODE_ACKIN_STO) ? MODE_STATUS_OUT : cur_mode;
					flag_set = 4'b0011;
					cnt_upd  = 1'b1;
				end else begin
					reply_d = REPLY_STALL;
					mode_d  = MODE_STALL_IO;
				end
			end
			ACT_ACK: if (good) begin
				reply_d  = REPLY_ACK;
				upd      = 1'b1;
				cnt_upd  = 1'b1;
				ev       = 1'b1;
				mode_d   = (ep == 2'h0) ? MODE_NAK_IO : MODE_NAK_OUT;
				flag_set = (ep == 2'h0) ? 4'b0011 : 4'b0001;
			end
			ACT_TX0, ACT_TXCNT: begin
				reply_d = REPLY_DATA;
				if (act == ACT_TXCNT) begin
					tx_len = (cnt_q[ep][3:0] > 4'(BUF_BYTES)) ? 4'(BUF_BYTES) : cnt_q[ep][3:0];
				end
			end
		endcase
	end

	// ==================================================================
	// Endpoint mode and count registers
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int e = 0; e < EP_NUM; e++) begin
				mode_q[e] <= MODE_RST;
				cnt_q[e]  <= CNT_RST;
			end
		end else begin
			for (int e = 0; e < EP_NUM; e++) begin
				if (i_reg_wr && i_reg_addr == REG_MODE_BASE + 8'(e)) begin
					mode_q[e] <= i_reg_wdata;
				end
				if (i_reg_wr && i_reg_addr == REG_COUNT_BASE + 8'(e)) begin
					cnt_q[e] <= i_reg_wdata;
				end
			end
			// Hardware updates win over a firmware write in the same cycle
			if (i_tok_valid && upd) begin
				mode_q[ep] <= {mode_q[ep][7:4] | flag_set |
					((i_reg_wr && i_reg_addr == REG_MODE_BASE + 8'(ep)) ? i_reg_wdata[7:4] : 4'h0), mode_d};
				if (cnt_upd) begin
					cnt_q[ep] <= {tog_d, 1'b1, cnt_q[ep][CNT_F_STALL], 1'b0, cnt_d};
				end
			end else if (i_host_ack && pend_q) begin
				unique case (mode_q[pend_ep_q][3:0])
					MODE_ACKIN_STO: mode_q[pend_ep_q] <= {mode_q[pend_ep_q][7:4] | 4'b0101, MODE_NAK_IO};
					MODE_ACKOUT_STI,
					MODE_STATUS_IN: mode_q[pend_ep_q] <= {mode_q[pend_ep_q][7:4] | 4'b0101, MODE_STALL_IO};
					MODE_ACK_IN:    mode_q[pend_ep_q] <= {mode_q[pend_ep_q][7:4] | 4'b0001, MODE_NAK_IN};
					default:        mode_q[pend_ep_q] <= mode_q[pend_ep_q];
				endcase
			end
		end
	end

	// ==================================================================
	// Replies, events and pending IN
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_reply_valid <= 1'b0;
			o_reply_code  <= REPLY_NONE;
			o_reply_len   <= 4'h0;
			o_ep_event    <= '0;
			pend_q        <= 1'b0;
			pend_ep_q     <= 2'h0;
		end else begin
			o_reply_valid <= i_tok_valid && (reply_d != REPLY_NONE);
			o_reply_code  <= i_tok_valid ? reply_d : REPLY_NONE;
			o_reply_len   <= (i_tok_valid && reply_d == REPLY_DATA) ? tx_len : 4'h0;
			o_ep_event    <= '0;
			if (i_tok_valid) begin
				pend_q    <= (reply_d == REPLY_DATA);
				pend_ep_q <= ep;
				if (ev) begin
					o_ep_event[ep] <= 1'b1;
				end
			end else if (i_host_ack && pend_q) begin
				pend_q                <= 1'b0;
				o_ep_event[pend_ep_q] <= (mode_q[pend_ep_q][3:0] != MODE_DISABLE);
			end
		end
	end

	// ==================================================================
	// Receive data into the endpoint buffers
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_idx_q <= 4'h0;
		end else if (i_tok_valid) begin
			rx_idx_q <= 4'h0;
		end else if (i_rx_valid && rx_idx_q != 4'hf) begin
			rx_idx_q <= rx_idx_q + 4'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (rx_store) begin
			mem_q[{i_rx_ep, 3'b000} + 5'(rx_idx_q)] <= i_rx_data;
		end else if (i_reg_wr && i_reg_addr >= REG_DATA_BASE && i_reg_addr < REG_DATA_BASE + 8'(EP_NUM*BUF_BYTES)) begin
			mem_q[5'(i_reg_addr - REG_DATA_BASE)] <= i_reg_wdata;
		end
	end

	// ==================================================================
	// Transmit counted data through the buffer
	assign tx_push = (tx_left_q != 4'h0) && fifo_ready;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_left_q <= 4'h0;
			tx_idx_q  <= 3'h0;
			tx_ep_q   <= 2'h0;
		end else if (i_tok_valid && reply_d == REPLY_DATA && tx_left_q == 4'h0) begin
			tx_left_q <= tx_len;
			tx_idx_q  <= 3'h0;
			tx_ep_q   <= ep;
		end else if (tx_push) begin
			tx_left_q <= tx_left_q - 4'h1;
			tx_idx_q  <= tx_idx_q + 3'h1;
		end
	end

	uemr_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.i_clk       (i_clk),
		.i_rst_b     (i_rst_b),
		.i_in_valid  (tx_left_q != 4'h0),
		.o_in_ready  (fifo_ready),
		.i_in_data   ({tx_left_q == 4'h1, mem_q[{tx_ep_q, tx_idx_q}]}),
		.o_out_valid (fifo_valid),
		.i_out_ready (i_tx_ready),
		.o_out_data  (fifo_data)
	);

	assign o_tx_valid = fifo_valid;
	assign o_tx_data  = fifo_data[7:0];
	assign o_tx_last  = fifo_data[8];

	// ==================================================================
	// Register read port
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_reg_rdata <= 8'h00;
		end else begin
			o_reg_rdata <= 8'h00;
			if (i_reg_rd) begin
				for (int e = 0; e < EP_NUM; e++) begin
					if (i_reg_addr == REG_MODE_BASE + 8'(e)) begin
						o_reg_rdata <= mode_q[e];
					end
					if (i_reg_addr == REG_COUNT_BASE + 8'(e)) begin
						o_reg_rdata <= cnt_q[e];
					end
				end
				if (i_reg_addr >= REG_DATA_BASE && i_reg_addr < REG_DATA_BASE + 8'(EP_NUM*BUF_BYTES)) begin
					o_reg_rdata <= mem_q[5'(i_reg_addr - REG_DATA_BASE)];
				end
			end
		end
	end

	// ==================================================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	logic ep0_tok;
	assign ep0_tok = i_tok_valid && i_tok_ep == 2'h0 && !i_reg_wr;

	a_nak_out_mode: assert property (ep0_tok && mode_q[0][3:0] == MODE_NAK_IO && i_tok_type == TOK_OUT && good
		|=> o_reply_code == REPLY_NAK && mode_q[0][3:0] == MODE_NAK_IO && o_ep_event == '0)
		else $error("NAK mode OUT reply wrong");
	a_setup_stall_ack: assert property (ep0_tok && mode_q[0][3:0] == MODE_STALL_IO && i_tok_type == TOK_SETUP && good
		|=> o_reply_code == REPLY_ACK && mode_q[0][3:0] == MODE_NAK_IO && mode_q[0][MODE_F_SETUP] && o_ep_event[0])
		else $error("SETUP in stall mode not taken");
	a_long_setup: assert property (ep0_tok && i_tok_type == TOK_SETUP && i_tok_count > 4'(MAX_PKT)
		|=> !o_reply_valid)
		else $error("Long SETUP answered");
	a_bad_setup: assert property (ep0_tok && i_tok_type == TOK_SETUP && !i_tok_dval
		|=> !o_reply_valid && $stable(mode_q[0]))
		else $error("Invalid SETUP changed state");
	a_stall_out_quiet: assert property (ep0_tok && mode_q[0][3:0] == MODE_STALL_IO && i_tok_type == TOK_OUT && good
		|=> o_reply_code == REPLY_STALL && o_ep_event == '0 && $stable(cnt_q[0]))
		else $error("Stall mode OUT wrong");
	a_good_status: assert property (ep0_tok && mode_q[0][3:0] == MODE_ACKIN_STO && i_tok_type == TOK_OUT && good &&
		i_tok_count == 4'(STAT_CNT) && i_tok_toggle
		|=> o_reply_code == REPLY_ACK && mode_q[0][3:0] == MODE_STATUS_OUT && cnt_q[0][3:0] == 4'(STAT_CNT) && o_ep_event[0])
		else $error("Good status not taken");
	a_bad_status: assert property (ep0_tok && mode_q[0][3:0] == MODE_ACKIN_STO && i_tok_type == TOK_OUT && good &&
		(i_tok_count != 4'(STAT_CNT) || !i_tok_toggle)
		|=> o_reply_code == REPLY_STALL && mode_q[0][3:0] == MODE_STALL_IO && o_ep_event[0])
		else $error("Bad status not stalled");
	a_disabled_quiet: assert property (i_tok_valid && i_tok_ep < 2'(EP_NUM) && mode_q[i_tok_ep][3:0] == MODE_DISABLE
		|=> !o_reply_valid ##1 !o_tx_valid)
		else $error("Disabled endpoint replied");
	a_tx_count_len: assert property (ep0_tok && mode_q[0][3:0] == MODE_ACKIN_STO && i_tok_type == TOK_IN &&
		cnt_q[0][3:0] <= 4'(BUF_BYTES)
		|=> o_reply_code == REPLY_DATA && o_reply_len == $past(cnt_q[0][3:0]))
		else $error("TX count length wrong");
	a_data_out_ack: assert property (i_tok_valid && i_tok_ep == 2'h1 && !i_reg_wr && mode_q[1][3:0] == MODE_ACK_OUT &&
		!cnt_q[1][CNT_F_STALL] && i_tok_type == TOK_OUT && good
		|=> o_reply_code == REPLY_ACK && mode_q[1][3:0] == MODE_NAK_OUT)
		else $error("Data OUT ACK mode not moved");
endmodule

// ### test/uemr_host_model.sv
`timescale 1ns/10ps
module uemr_host_model
	import uemr_pkg::*;
(
	input  wire logic              i_clk,
	output logic                   o_tok_valid,
	output logic [1:0]             o_tok_type,
	output logic [1:0]             o_tok_ep,
	output logic [3:0]             o_tok_count,
	output logic                   o_tok_dval,
	output logic                   o_tok_toggle,
	output logic                   o_host_ack,
	output logic                   o_rx_valid,
	output logic                   o_rx_setup,
	output logic [1:0]             o_rx_ep,
	output logic [7:0]             o_rx_data,
	output logic                   o_tx_ready,
	input  wire logic              i_reply_valid,
	input  wire logic [2:0]        i_reply_code,
	input  wire logic [3:0]        i_reply_len,
	input  wire logic [EP_NUM-1:0] i_ep_event,
	input  wire logic              i_tx_valid,
	input  wire logic [7:0]        i_tx_data,
	input  wire logic              i_tx_last
);
	logic       ready_en = 1'b1;
	logic [1:0] cyc_q    = 2'h0;
	logic [8:0] rx_q[$];

	initial begin
		{o_tok_valid, o_tok_type, o_tok_ep, o_tok_count, o_tok_dval, o_tok_toggle} = '0;
		{o_host_ack, o_rx_valid, o_rx_setup, o_rx_ep, o_rx_data} = '0;
	end

	// =============================================
	// Slow receiver: accepts every other cycle while enabled
	always @(posedge i_clk) begin
		cyc_q <= cyc_q + 2'h1;
		o_tx_ready <= ready_en & cyc_q[0];
		if (i_tx_valid && o_tx_ready) begin
			rx_q.push_back({i_tx_last, i_tx_data});
		end
	end

	// =============================================
	// Data bytes first, then the token summary; idle lines show inverted values
	task automatic send(input logic [1:0] ty, input logic [1:0] ep, input logic [3:0] cnt, input logic dv,
			input logic tg, input logic [7:0] seed, output logic [2:0] code, output logic [3:0] len,
			output logic [EP_NUM-1:0] ev);
		int i;
		int nb;
		nb = (cnt > 2) ? cnt - 2 : 0;
		for (i = 0; i < nb; i++) begin
			@(posedge i_clk);
			o_rx_valid <= 1'b1;
			o_rx_setup <= (ty == TOK_SETUP);
			o_rx_ep <= ep;
			o_rx_data <= seed + 8'(i);
		end
		@(posedge i_clk);
		o_rx_valid <= 1'b0;
		o_rx_data <= ~o_rx_data;
		o_tok_valid <= 1'b1;
		{o_tok_type, o_tok_ep, o_tok_count, o_tok_dval, o_tok_toggle} <= {ty, ep, cnt, dv, tg};
		@(posedge i_clk);
		o_tok_valid <= 1'b0;
		{o_tok_type, o_tok_ep, o_tok_count, o_tok_dval, o_tok_toggle} <= ~{ty, ep, cnt, dv, tg};
		#1;
		code = i_reply_valid ? i_reply_code : REPLY_NONE;
		len = i_reply_len;
		ev = i_ep_event;
	endtask

	task automatic ack(output logic [EP_NUM-1:0] ev);
		@(posedge i_clk);
		o_host_ack <= 1'b1;
		@(posedge i_clk);
		o_host_ack <= 1'b0;
		#1;
		ev = i_ep_event;
	endtask
endmodule

// ### test/uemr_responder_bench.sv
`timescale 1ns/10ps
module uemr_responder_bench
	import uemr_pkg::*;
;
	logic clk = 1'b0, rst_b = 1'b0, tok_valid, tok_dval, tok_toggle, host_ack, rx_valid, rx_setup, tx_ready;
	logic [1:0] tok_type, tok_ep, rx_ep;
	logic [3:0] tok_count, reply_len;
	logic [7:0] rx_data, tx_data, reg_rdata;
	logic reply_valid, tx_valid, tx_last, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [2:0] reply_code, c;
	logic [EP_NUM-1:0] ep_event, v;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [3:0] l;
	int error_cnt = 0, tests_run = 0;

	always #2.5 clk = ~clk;

	uemr_responder uemr_responder_i (.i_clk(clk), .i_rst_b(rst_b), .i_tok_valid(tok_valid), .i_tok_type(tok_type),
		.i_tok_ep(tok_ep), .i_tok_count(tok_count), .i_tok_dval(tok_dval), .i_tok_toggle(tok_toggle),
		.i_host_ack(host_ack), .i_rx_valid(rx_valid), .i_rx_setup(rx_setup), .i_rx_ep(rx_ep), .i_rx_data(rx_data),
		.o_reply_valid(reply_valid), .o_reply_code(reply_code), .o_reply_len(reply_len), .o_tx_valid(tx_valid),
		.i_tx_ready(tx_ready), .o_tx_data(tx_data), .o_tx_last(tx_last), .o_ep_event(ep_event),
		.i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata));

	uemr_host_model host_i (.i_clk(clk), .o_tok_valid(tok_valid), .o_tok_type(tok_type), .o_tok_ep(tok_ep),
		.o_tok_count(tok_count), .o_tok_dval(tok_dval), .o_tok_toggle(tok_toggle), .o_host_ack(host_ack),
		.o_rx_valid(rx_valid), .o_rx_setup(rx_setup), .o_rx_ep(rx_ep), .o_rx_data(rx_data), .o_tx_ready(tx_ready),
		.i_reply_valid(reply_valid), .i_reply_code(reply_code), .i_reply_len(reply_len), .i_ep_event(ep_event),
		.i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_tx_last(tx_last));

	// =============================================
	// Shared helpers
	task automatic results();
		if (error_cnt == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, seen);
			error_cnt++;
		end
	endtask

	task automatic reg_wr_t(input logic [7:0] a, input logic [7:0] w);
		@(posedge clk);
		reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= w;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1; reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check("reg_rdata", reg_rdata, exp);
	endtask

	task automatic tok_chk(input logic [1:0] ty, input logic [1:0] ep, input logic [3:0] cnt, input logic dv,
			input logic tg, input logic [2:0] ec, input logic [EP_NUM-1:0] ee);
		host_i.send(ty, ep, cnt, dv, tg, 8'h40, c, l, v);
		check("reply_code", 8'(c), 8'(ec));
		check("ep_event", 8'(v), 8'(ee));
	endtask

	task automatic drain(input int n);
		int i;
		for (i = 0; i < 300 && host_i.rx_q.size() < n; i++) @(posedge clk);
		check("tx_count", 8'(host_i.rx_q.size()), 8'(n));
		if (host_i.rx_q.size() != n) results();
	endtask

	// =============================================
	// Scenarios
	task automatic t_control();
		int e;
		for (e = 0; e < EP_NUM; e++) rd_chk(REG_COUNT_BASE + 8'(e), CNT_RST);
		reg_wr_t(8'hff, 8'h5a);
		rd_chk(8'hff, 8'h00);
		for (e = 0; e < 3; e++) tok_chk(2'(e), 2'h0, 4'ha, 1'b1, 1'b1, REPLY_NONE, 3'h0);
		rd_chk(REG_MODE_BASE, MODE_RST);
		reg_wr_t(REG_MODE_BASE, 8'h03);
		tok_chk(TOK_OUT, 2'h0, 4'h2, 1'b1, 1'b1, REPLY_STALL, 3'h0);
		tok_chk(TOK_SETUP, 2'h0, 4'hb, 1'b1, 1'b0, REPLY_NONE, 3'h0);
		tok_chk(TOK_SETUP, 2'h0, 4'ha, 1'b0, 1'b0, REPLY_NONE, 3'h0);
		rd_chk(REG_MODE_BASE, 8'h03);
		tok_chk(TOK_SETUP, 2'h0, 4'ha, 1'b1, 1'b0, REPLY_ACK, 3'h1);
		rd_chk(REG_MODE_BASE, 8'h91);
		rd_chk(REG_DATA_BASE + 8'h07, 8'h47);
		tok_chk(TOK_IN, 2'h0, 4'h2, 1'b1, 1'b1, REPLY_NAK, 3'h0);
		tok_chk(TOK_OUT, 2'h0, 4'h2, 1'b1, 1'b1, REPLY_NAK, 3'h0);
		rd_chk(REG_MODE_BASE, 8'h91);
	endtask

	task automatic t_status();
		logic [7:0] md[6] = '{8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h02, 8'h02};
		logic [7:0] mx[6] = '{8'h32, 8'h03, 8'h03, 8'h0f, 8'h32, 8'h03};
		logic [3:0] cn[6] = '{4'h2, 4'h5, 4'h2, 4'h2, 4'h2, 4'h2};
		logic [2:0] rc[6] = '{REPLY_ACK, REPLY_STALL, REPLY_STALL, REPLY_NONE, REPLY_ACK, REPLY_STALL};
		logic [5:0] dv = 6'b110111, tg = 6'b011001;
		int i;
		for (i = 0; i < 6; i++) begin
			reg_wr_t(REG_MODE_BASE, md[i]);
			tok_chk(TOK_OUT, 2'h0, cn[i], dv[i], tg[i], rc[i], {2'h0, dv[i]});
			rd_chk(REG_MODE_BASE, mx[i]);
			if (rc[i] == REPLY_ACK) rd_chk(REG_COUNT_BASE, 8'hc2);
		end
		reg_wr_t(REG_MODE_BASE, 8'h02);
		tok_chk(TOK_IN, 2'h0, 4'h2, 1'b1, 1'b1, REPLY_STALL, 3'h1);
		rd_chk(REG_MODE_BASE, 8'h03);
	endtask

	task automatic t_tx();
		int i;
		reg_wr_t(REG_COUNT_BASE, 8'h03);
		for (i = 0; i < 3; i++) reg_wr_t(REG_DATA_BASE + 8'(i), 8'ha0 + 8'(i));
		reg_wr_t(REG_MODE_BASE, 8'h0f);
		host_i.ready_en <= 1'b0;
		tok_chk(TOK_IN, 2'h0, 4'h2, 1'b1, 1'b1, REPLY_DATA, 3'h0);
		check("reply_len", 8'(l), 8'h03);
		repeat (20) @(posedge clk);
		#1;
		check("tx_valid_stall", 8'(tx_valid), 8'h01);
		host_i.ready_en <= 1'b1;
		drain(3);
		for (i = 0; i < 3; i++) check("tx_data", 8'(host_i.rx_q[i]), 8'ha0 + 8'(i));
		for (i = 0; i < 3; i++) check("tx_last", 8'(host_i.rx_q[i][8]), 8'(i == 2));
		host_i.ack(v);
		check("ack_event", 8'(v), 8'h01);
		rd_chk(REG_MODE_BASE, 8'h51);
		reg_wr_t(REG_MODE_BASE, 8'h0b);
		tok_chk(TOK_IN, 2'h0, 4'h2, 1'b1, 1'b1, REPLY_DATA, 3'h0);
		host_i.ack(v);
		rd_chk(REG_MODE_BASE, 8'h53);
		host_i.rx_q.delete();
		reg_wr_t(REG_MODE_BASE, 8'h0f);
		tok_chk(TOK_IN, 2'h0, 4'h2, 1'b1, 1'b1, REPLY_DATA, 3'h0);
		drain(3);
		rd_chk(REG_MODE_BASE, 8'h0f);
	endtask

	task automatic t_data_reserved();
		logic [7:0] rs[5] = '{8'h05, 8'h07, 8'h0a, 8'h04, 8'h0e};
		int i, t;
		reg_wr_t(REG_MODE_BASE + 8'h01, 8'h09);
		tok_chk(TOK_OUT, 2'h1, 4'h4, 1'b1, 1'b0, REPLY_ACK, 3'h2);
		rd_chk(REG_MODE_BASE + 8'h01, 8'h18);
		tok_chk(TOK_OUT, 2'h1, 4'h2, 1'b1, 1'b1, REPLY_NAK, 3'h0);
		host_i.rx_q.delete();
		reg_wr_t(REG_COUNT_BASE + 8'h01, 8'h01);
		reg_wr_t(REG_MODE_BASE + 8'h01, 8'h0d);
		tok_chk(TOK_IN, 2'h1, 4'h2, 1'b1, 1'b1, REPLY_DATA, 3'h0);
		drain(1);
		host_i.ack(v);
		rd_chk(REG_MODE_BASE + 8'h01, 8'h1c);
		tok_chk(TOK_IN, 2'h1, 4'h2, 1'b1, 1'b1, REPLY_NAK, 3'h0);
		reg_wr_t(REG_COUNT_BASE + 8'h01, 8'h20);
		reg_wr_t(REG_MODE_BASE + 8'h01, 8'h0d);
		tok_chk(TOK_IN, 2'h1, 4'h2, 1'b1, 1'b1, REPLY_STALL, 3'h0);
		reg_wr_t(REG_MODE_BASE, 8'h06);
		tok_chk(TOK_OUT, 2'h0, 4'h2, 1'b1, 1'b1, REPLY_STALL, 3'h1);
		rd_chk(REG_MODE_BASE, 8'h03);
		for (i = 0; i < 5; i++) begin
			reg_wr_t(REG_MODE_BASE, rs[i]);
			for (t = 0; t < 3; t++) tok_chk(2'(t), 2'h0, 4'h2, 1'b1, 1'b1, REPLY_NONE, 3'h0);
			rd_chk(REG_MODE_BASE, rs[i]);
		end
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		t_control();
		t_status();
		t_tx();
		t_data_reserved();
		results();
	end
endmodule
